// file: design/device_config_word0_decode.sv
// Decoder of configuration word zero with AXI4-Lite register access
//
// The register addresses and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
module device_config_word0_decode (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    // Nonvolatile memory
    output logic nvm_rd,
    input wire logic [31:0] nvm_data,
    input wire logic [31:0] device_signature_word_zero,
    // Pin and CPU inputs
    input wire logic master_clear_pin_n,
    input wire logic cpu_debug_mode,
    // Decoded controls
    output logic cfg_valid,
    output logic debug_boot_enable,
    output logic primary_osc_boost,
    output logic [1:0] primary_osc_gain,
    output logic secondary_osc_boost,
    output logic [1:0] secondary_osc_gain,
    output logic soft_master_clear_enable,
    output logic [2:0] debug_permission_mask,
    output logic test_port_enable,
    output logic [1:0] effective_perm_group,
    output logic sys_reset_req,
    output logic por_reset_req,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // ------------------------------------------------------------
    // Loader
    // ------------------------------------------------------------
    logic [31:0] nvm_word;
    logic load_done;

    cfg0_loader u_loader (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .nvm_rd(nvm_rd),
        .nvm_data(nvm_data),
        .word(nvm_word),
        .done(load_done)
    );

    function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0] strb);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // Decoded state
    // ------------------------------------------------------------
    logic [31:0] cfg_q, cfg_d;
    logic valid_q, valid_d;
    logic captured_q, captured_d;
    logic rt_test_q, rt_test_d;
    logic [1:0] group_q, group_d;
    logic [1:0] eff_q, eff_d;
    logic [2:0] pin_sync_q, pin_sync_d;
    logic pin_state_q, pin_state_d;
    logic sys_q, sys_d;
    logic por_q, por_d;
    logic wr_fire;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic pin_fall;

    always_comb begin
        cfg_d = cfg_q;
        valid_d = valid_q;
        captured_d = captured_q;
        rt_test_d = rt_test_q;
        group_d = group_q;
        pin_sync_d = {pin_sync_q[1:0], master_clear_pin_n};
        pin_state_d = pin_state_q;
        pin_fall = 1'b0;
        if (!captured_q && load_done) begin
            cfg_d = nvm_word;
            cfg_d[cfg0_pkg::SIG_RSVD_BIT] =
                device_signature_word_zero[cfg0_pkg::SIG_RSVD_BIT];
            rt_test_d = nvm_word[cfg0_pkg::TEST_PORT_BIT];
            captured_d = 1'b1;
            valid_d = 1'b1;
        end
        if (wr_fire && wr_addr == cfg0_pkg::OFF_RUNTIME_CTRL && wr_strb[0]) begin
            rt_test_d = wr_data[cfg0_pkg::RT_TEST_PORT_BIT];
        end
        if (wr_fire && wr_addr == cfg0_pkg::OFF_PERM_GROUP) begin
            group_d = 2'(merge_strb({30'h0, group_q}, wr_data, wr_strb));
        end
        // Change counts once second and third stages agree
        if (pin_sync_q[1] == pin_sync_q[2] && pin_sync_q[2] != pin_state_q) begin
            pin_state_d = pin_sync_q[2];
            pin_fall = !pin_sync_q[2];
        end
        // Denied groups drop to the fallback group while debugging
        eff_d = group_q;
        if (cpu_debug_mode && group_q != cfg0_pkg::GROUP_FALLBACK
            && !cfg_q[cfg0_pkg::DBG_PERM_LO + 32'(group_q)]) begin
            eff_d = cfg0_pkg::GROUP_FALLBACK;
        end
        // Reset kind chosen by soft master clear; no request before load
        sys_d = pin_fall && valid_q && cfg_q[cfg0_pkg::SOFT_CLEAR_BIT];
        por_d = pin_fall && valid_q && !cfg_q[cfg0_pkg::SOFT_CLEAR_BIT];
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            cfg_q <= cfg0_pkg::CFG_RESET;
            valid_q <= 1'b0;
            captured_q <= 1'b0;
            rt_test_q <= 1'b0;
            group_q <= 2'h0;
            eff_q <= 2'h0;
            pin_sync_q <= 3'h7;
            pin_state_q <= 1'b1;
            sys_q <= 1'b0;
            por_q <= 1'b0;
        end else if (ce) begin
            cfg_q <= cfg_d;
            valid_q <= valid_d;
            captured_q <= captured_d;
            rt_test_q <= rt_test_d;
            group_q <= group_d;
            eff_q <= eff_d;
            pin_sync_q <= pin_sync_d;
            pin_state_q <= pin_state_d;
            sys_q <= sys_d;
            por_q <= por_d;
        end
    end

    assign cfg_valid = valid_q;
    assign debug_boot_enable = cfg_q[cfg0_pkg::DBG_BOOT_BIT];
    assign primary_osc_boost = cfg_q[cfg0_pkg::POSC_BOOST_BIT];
    assign primary_osc_gain = cfg_q[cfg0_pkg::POSC_GAIN_LO +: 2];
    assign secondary_osc_boost = cfg_q[cfg0_pkg::SOSC_BOOST_BIT];
    assign secondary_osc_gain = cfg_q[cfg0_pkg::SOSC_GAIN_LO +: 2];
    assign soft_master_clear_enable = cfg_q[cfg0_pkg::SOFT_CLEAR_BIT];
    assign debug_permission_mask = cfg_q[cfg0_pkg::DBG_PERM_LO +: 3];
    assign test_port_enable = rt_test_q;
    assign effective_perm_group = eff_q;
    assign sys_reset_req = sys_q;
    assign por_reset_req = por_q;

    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------
    logic aw_full_q, aw_full_d;
    logic w_full_q, w_full_d;
    logic [7:0] awaddr_q, awaddr_d;
    logic [31:0] wdata_q, wdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    logic arready_q, arready_d;
    logic rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0] rresp_q, rresp_d;

    assign wr_fire = aw_full_q && w_full_q && !bvalid_q;
    assign wr_addr = awaddr_q;
    assign wr_data = wdata_q;
    assign wr_strb = wstrb_q;

    function automatic logic [1:0] wr_resp(input logic [7:0] a);
        case (a)
            cfg0_pkg::OFF_RUNTIME_CTRL, cfg0_pkg::OFF_PERM_GROUP: wr_resp = cfg0_pkg::RESP_OKAY;
            // The word itself is fixed after power-on
            cfg0_pkg::OFF_CFG_WORD, cfg0_pkg::OFF_STATUS,
            cfg0_pkg::OFF_SIGNATURE, cfg0_pkg::OFF_MEM_CFG: wr_resp = cfg0_pkg::RESP_SLVERR;
            default: wr_resp = cfg0_pkg::RESP_DECERR;
        endcase
    endfunction

    always_comb begin
        aw_full_d = aw_full_q;
        w_full_d = w_full_q;
        awaddr_d = awaddr_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        arready_d = 1'b0;
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        // Taken only on a real handshake; ready is low right after reset
        if (s_axi_awvalid && s_axi_awready && !aw_full_q) begin
            aw_full_d = 1'b1;
            awaddr_d = {s_axi_awaddr[7:2], 2'b00};
        end
        if (s_axi_wvalid && s_axi_wready && !w_full_q) begin
            w_full_d = 1'b1;
            wdata_d = s_axi_wdata;
            wstrb_d = s_axi_wstrb;
        end
        if (wr_fire) begin
            bvalid_d = 1'b1;
            bresp_d = wr_resp(awaddr_q);
        end
        if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
            aw_full_d = 1'b0;
            w_full_d = 1'b0;
        end
        // Data follows the address handshake, never precedes it
        if (s_axi_arvalid && !arready_q && !rvalid_q) begin
            arready_d = 1'b1;
        end
        if (s_axi_arvalid && arready_q) begin
            rvalid_d = 1'b1;
            rresp_d = cfg0_pkg::RESP_OKAY;
            case ({s_axi_araddr[7:2], 2'b00})
                cfg0_pkg::OFF_CFG_WORD: rdata_d = cfg_q;
                cfg0_pkg::OFF_STATUS: rdata_d = {31'h0, valid_q};
                cfg0_pkg::OFF_RUNTIME_CTRL: rdata_d = 32'(rt_test_q) << cfg0_pkg::RT_TEST_PORT_BIT;
                cfg0_pkg::OFF_SIGNATURE: rdata_d = device_signature_word_zero;
                cfg0_pkg::OFF_PERM_GROUP: rdata_d = {30'h0, group_q};
                cfg0_pkg::OFF_MEM_CFG: rdata_d = nvm_word;
                default: begin
                    rdata_d = cfg0_pkg::ZERO_WORD;
                    rresp_d = cfg0_pkg::RESP_DECERR;
                end
            endcase
        end
        if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= 2'h0;
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= 2'h0;
        end else if (ce) begin
            aw_full_q <= aw_full_d;
            w_full_q <= w_full_d;
            awaddr_q <= awaddr_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            arready_q <= arready_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
        end
    end

    // Ready is offered while the slot is free
    always_ff @(posedge clk) begin
        if (!nrst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else if (ce) begin
            s_axi_awready <= !aw_full_d;
            s_axi_wready <= !w_full_d;
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
endmodule

// file: design/cfg0_pkg.sv
// Constants for the configuration word zero decoder
package cfg0_pkg;
    // AXI4-Lite byte offsets
    localparam logic [7:0] OFF_CFG_WORD = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_RUNTIME_CTRL = 8'h08;
    localparam logic [7:0] OFF_SIGNATURE = 8'h0c;
    localparam logic [7:0] OFF_PERM_GROUP = 8'h10;
    localparam logic [7:0] OFF_MEM_CFG = 8'h14;
    // Field positions in the configuration word
    localparam int SIG_RSVD_BIT = 31;
    localparam int DBG_BOOT_BIT = 30;
    localparam int RSVD_HI = 29;
    localparam int RSVD_LO = 22;
    localparam int POSC_BOOST_BIT = 21;
    localparam int POSC_GAIN_LO = 19;
    localparam int SOSC_BOOST_BIT = 18;
    localparam int SOSC_GAIN_LO = 16;
    localparam int SOFT_CLEAR_BIT = 15;
    localparam int DBG_PERM_LO = 12;
    localparam int TOOL_RSVD_BIT = 11;
    localparam int TEST_PORT_BIT = 2;
    // Runtime control register layout
    localparam int RT_TEST_PORT_BIT = 3;
    // Fallback group for denied debug accesses
    localparam logic [1:0] GROUP_FALLBACK = 2'h3;
    // Reset values
    localparam logic [31:0] CFG_RESET = 32'hffff_ffff;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
    // Arbitrary neutral signature default
    localparam logic [31:0] SIGNATURE_DEFAULT = 32'h0000_0000;
    // Nonvolatile read latency in cycles
    localparam logic [3:0] NVM_WAIT = 4'h2;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage

// file: design/cfg0_loader.sv
// One-shot loader of the configuration word from nonvolatile memory
`timescale 1ns/1ps
module cfg0_loader (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    output logic nvm_rd,
    input wire logic [31:0] nvm_data,
    output logic [31:0] word,
    output logic done
);
    typedef enum logic [1:0] {ST_REQ, ST_WAIT, ST_DONE} load_t;
    load_t state_q, state_d;
    logic [3:0] cnt_q, cnt_d;
    logic [31:0] word_q, word_d;
    logic rd_q, rd_d;

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        word_d = word_q;
        rd_d = 1'b0;
        case (state_q)
            ST_REQ: begin
                rd_d = 1'b1;
                cnt_d = cfg0_pkg::NVM_WAIT;
                state_d = ST_WAIT;
            end
            ST_WAIT: begin
                if (cnt_q == 4'h0) begin
                    word_d = nvm_data;
                    state_d = ST_DONE;
                end else begin
                    cnt_d = cnt_q - 4'h1;
                end
            end
            ST_DONE: begin
                // Held until the next power-on reset
                state_d = ST_DONE;
            end
            default: state_d = ST_REQ;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_q <= ST_REQ;
            cnt_q <= 4'h0;
            word_q <= cfg0_pkg::CFG_RESET;
            rd_q <= 1'b0;
        end else if (ce) begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            word_q <= word_d;
            rd_q <= rd_d;
        end
    end

    assign nvm_rd = rd_q;
    assign word = word_q;
    assign done = (state_q == ST_DONE);
endmodule

// file: testbench/cfg0_decode_checker.sv
// Assertion checker for the configuration word zero decoder
`timescale 1ns/1ps
module cfg0_decode_checker (
    input wire logic clk,
    input wire logic nrst,
    input wire logic nvm_rd,
    input wire logic master_clear_pin_n,
    input wire logic cpu_debug_mode,
    input wire logic cfg_valid,
    input wire logic debug_boot_enable,
    input wire logic primary_osc_boost,
    input wire logic [1:0] primary_osc_gain,
    input wire logic secondary_osc_boost,
    input wire logic [1:0] secondary_osc_gain,
    input wire logic soft_master_clear_enable,
    input wire logic [2:0] debug_permission_mask,
    input wire logic [1:0] effective_perm_group,
    input wire logic sys_reset_req,
    input wire logic por_reset_req,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    logic [10:0] fields;
    assign fields = {debug_boot_enable, primary_osc_boost, primary_osc_gain, secondary_osc_boost,
                     secondary_osc_gain, soft_master_clear_enable, debug_permission_mask};
    AST_FIELDS_HELD: assert property (cfg_valid && $past(cfg_valid) |-> $stable(fields))
        else $error("decoded fields moved while loaded");
    AST_VALID_KEPT: assert property (cfg_valid |=> cfg_valid)
        else $error("load flag dropped");
    AST_LOAD_ONCE: assert property (cfg_valid |-> !nvm_rd)
        else $error("second load request");
    AST_LOAD_DONE: assert property (nvm_rd |-> ##[1:8] cfg_valid)
        else $error("load did not finish");
    // Lag of one cycle, so the debug state one edge back decides the group
    AST_DEBUG_GROUP: assert property ($past(cpu_debug_mode) && cfg_valid && $past(cfg_valid)
        && effective_perm_group != 2'h3 |-> debug_permission_mask[effective_perm_group])
        else $error("denied group passed in debug mode");
    AST_SYS_KIND: assert property (sys_reset_req |-> soft_master_clear_enable && !por_reset_req
        && cfg_valid)
        else $error("system reset request with wrong mode");
    AST_POR_KIND: assert property (por_reset_req |-> !soft_master_clear_enable && cfg_valid)
        else $error("power-on reset request with wrong mode");
    AST_PIN_CAUSE: assert property (sys_reset_req || por_reset_req
        |-> !$past(master_clear_pin_n, 3))
        else $error("reset request without pin low");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata))
        else $error("read data not held");
    cover property ($rose(cfg_valid));
    cover property (sys_reset_req);
    cover property (por_reset_req);
    cover property (cpu_debug_mode && effective_perm_group == 2'h3);
endmodule

bind device_config_word0_decode cfg0_decode_checker u_cfg0_decode_checker (
    .clk, .nrst, .nvm_rd, .master_clear_pin_n, .cpu_debug_mode, .cfg_valid, .debug_boot_enable,
    .primary_osc_boost, .primary_osc_gain, .secondary_osc_boost, .secondary_osc_gain,
    .soft_master_clear_enable, .debug_permission_mask, .effective_perm_group, .sys_reset_req,
    .por_reset_req, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata
);

// file: testbench/cfg0_nvm_model.sv
// Nonvolatile configuration memory answering the one load request
`timescale 1ns/1ps
module cfg0_nvm_model (
    input wire logic clk,
    input wire logic nrst,
    input wire logic nvm_rd,
    input wire logic cfg_valid,
    input wire logic [31:0] word,
    output logic [31:0] nvm_data
);
    logic hold_q;
    logic hold_d;
    always_comb begin
        hold_d = hold_q;
        if (nvm_rd) begin
            hold_d = 1'b1;
        end else if (cfg_valid || !nrst) begin
            hold_d = 1'b0;
        end
    end
    always_ff @(posedge clk) begin
        hold_q <= hold_d;
    end
    // Inverted outside the load so a late capture cannot pass unseen
    assign nvm_data = (nvm_rd || hold_q) ? word : ~word;
endmodule

// file: testbench/device_config_word0_decode_tb.sv
// Self-checking testbench for the configuration word zero decoder
`timescale 1ns/1ps
module device_config_word0_decode_tb;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic ce = 1'b1;
    logic master_clear_pin_n = 1'b1;
    logic cpu_debug_mode = 1'b0;
    logic [31:0] nvm_word = 32'hffff_ffff;
    logic [31:0] device_signature_word_zero = 32'h0000_0000;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic nvm_rd, cfg_valid, debug_boot_enable, primary_osc_boost, secondary_osc_boost;
    logic soft_master_clear_enable, test_port_enable, sys_reset_req, por_reset_req;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] primary_osc_gain, secondary_osc_gain, effective_perm_group, s_axi_bresp, s_axi_rresp;
    logic [2:0] debug_permission_mask;
    logic [31:0] nvm_data, s_axi_rdata;
    int bad_count = 0;
    int tests_run = 0;

    always #10 clk = ~clk;

    cfg0_nvm_model u_cfg0_nvm_model (.clk, .nrst, .nvm_rd, .cfg_valid, .word(nvm_word), .nvm_data);
    device_config_word0_decode u_device_config_word0_decode (
        .clk, .nrst, .ce, .nvm_rd, .nvm_data, .device_signature_word_zero, .master_clear_pin_n,
        .cpu_debug_mode, .cfg_valid, .debug_boot_enable, .primary_osc_boost, .primary_osc_gain,
        .secondary_osc_boost, .secondary_osc_gain, .soft_master_clear_enable,
        .debug_permission_mask, .test_port_enable, .effective_perm_group, .sys_reset_req,
        .por_reset_req, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
    );

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", name, exp, got);
            bad_count++;
        end
    endtask

    // Handshakes judged at the falling edge, where the rising-edge values still stand
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                          output logic [1:0] r);
        logic aw, w, b;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        b = 1'b0;
        for (int k = 0; k < 40 && !b; k++) begin
            @(negedge clk);
            aw = s_axi_awvalid && s_axi_awready;
            w = s_axi_wvalid && s_axi_wready;
            b = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge clk);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar, v;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        v = 1'b0;
        for (int k = 0; k < 40 && !v; k++) begin
            @(negedge clk);
            ar = s_axi_arvalid && s_axi_arready;
            v = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge clk);
            if (ar) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
    endtask

    task automatic test_decode(input logic [1:0] i);
        logic [2:0] m;
        logic [31:0] w, d;
        logic [1:0] r, e;
        logic [15:0] sc, pc;
        m = {i[0], i[1], ~i[0]};
        w = {~i[1], i[0], 8'hff, i[0], i, ~i[0], ~i, i[1], m, 1'b1, 8'h00, i[0], 2'b00};
        @(posedge clk);
        nvm_word <= w;
        device_signature_word_zero <= {i[1], 31'h0000_0000};
        nrst <= 1'b0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        for (int k = 0; k < 20 && cfg_valid !== 1'b1; k++) @(negedge clk);
        check("fields", {20'h0_0000, i[0], i[0], i, ~i[0], ~i, i[1], m, i[0]}, {20'h0_0000,
            debug_boot_enable, primary_osc_boost, primary_osc_gain, secondary_osc_boost,
            secondary_osc_gain, soft_master_clear_enable, debug_permission_mask,
            test_port_enable});
        axi_rd(cfg0_pkg::OFF_CFG_WORD, d, r);
        check("cfg_word", {i[1], w[30:0]}, d);
        axi_rd(cfg0_pkg::OFF_RUNTIME_CTRL, d, r);
        check("runtime_test_port", {31'h0, i[0]}, {31'h0, d[cfg0_pkg::RT_TEST_PORT_BIT]});
        for (int g = 0; g < 4; g++) begin
            e = (g < 3 && !m[g]) ? cfg0_pkg::GROUP_FALLBACK : 2'(g);
            axi_wr(cfg0_pkg::OFF_PERM_GROUP, 32'(g), 4'hf, r);
            check("group_wr_resp", {30'h0, cfg0_pkg::RESP_OKAY}, {30'h0, r});
            cpu_debug_mode <= 1'b1;
            repeat (2) @(posedge clk);
            @(negedge clk);
            check("debug_group", {30'h0, e}, {30'h0, effective_perm_group});
            @(posedge clk);
            cpu_debug_mode <= 1'b0;
            repeat (2) @(posedge clk);
            @(negedge clk);
            check("normal_group", 32'(g), {30'h0, effective_perm_group});
        end
        @(posedge clk);
        master_clear_pin_n <= 1'b0;
        sc = 16'h0000;
        pc = 16'h0000;
        for (int k = 0; k < 12; k++) begin
            @(negedge clk);
            if (sys_reset_req === 1'b1) sc++;
            if (por_reset_req === 1'b1) pc++;
        end
        @(posedge clk);
        master_clear_pin_n <= 1'b1;
        repeat (6) @(posedge clk);
        check("reset_pulses", {15'h0, i[1], 15'h0, !i[1]}, {sc, pc});
    endtask

    task automatic test_bus();
        logic [31:0] d0, d;
        logic [15:0] sc;
        logic [1:0] r;
        axi_rd(cfg0_pkg::OFF_CFG_WORD, d0, r);
        axi_wr(cfg0_pkg::OFF_CFG_WORD, 32'h0000_0000, 4'hf, r);
        check("ro_write_resp", {30'h0, cfg0_pkg::RESP_SLVERR}, {30'h0, r});
        axi_rd(cfg0_pkg::OFF_CFG_WORD, d, r);
        check("cfg_word_kept", d0, d);
        axi_wr(8'h20, 32'hffff_ffff, 4'hf, r);
        check("unmapped_wr", {30'h0, cfg0_pkg::RESP_DECERR}, {30'h0, r});
        axi_rd(8'h20, d, r);
        check("unmapped_rd", {30'h0, cfg0_pkg::RESP_DECERR}, {30'h0, r});
        check("unmapped_data", cfg0_pkg::ZERO_WORD, d);
        axi_rd(cfg0_pkg::OFF_STATUS, d, r);
        check("status_loaded", 32'h0000_0001, {31'h0, d[0]});
        axi_rd(cfg0_pkg::OFF_PERM_GROUP, d, r);
        check("group_reg", 32'h0000_0003, {30'h0, d[1:0]});
        axi_wr(cfg0_pkg::OFF_RUNTIME_CTRL, 32'h0000_0000, 4'h1, r);
        @(negedge clk);
        check("test_port_clear", 32'h0000_0000, {31'h0, test_port_enable});
        axi_rd(cfg0_pkg::OFF_SIGNATURE, d, r);
        check("signature", device_signature_word_zero, d);
        axi_rd(cfg0_pkg::OFF_MEM_CFG, d, r);
        check("raw_word", nvm_word, d);
        // Clock enable low: a pin event must leave no trace
        @(posedge clk);
        ce <= 1'b0;
        master_clear_pin_n <= 1'b0;
        sc = 16'h0000;
        for (int k = 0; k < 10; k++) begin
            @(negedge clk);
            if (sys_reset_req === 1'b1 || por_reset_req === 1'b1) sc++;
        end
        @(posedge clk);
        master_clear_pin_n <= 1'b1;
        repeat (2) @(posedge clk);
        ce <= 1'b1;
        for (int k = 0; k < 6; k++) begin
            @(negedge clk);
            if (sys_reset_req === 1'b1 || por_reset_req === 1'b1) sc++;
        end
        check("frozen_pulses", 32'h0000_0000, {16'h0000, sc});
    endtask

    task automatic summarize();
        if (bad_count == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge clk);
        bad_count++;
        summarize();
    end

    initial begin
        for (int i = 0; i < 4; i++) begin
            test_decode(2'(i));
        end
        test_bus();
        summarize();
    end
endmodule
